// File: bench/amp_sequencer_agc_mode_ctrl_tb.sv
`timescale 1ns/1ps
module amp_sequencer_agc_mode_ctrl_tb;
	import asamc_pkg::*;
	logic            clk;
	logic            rst;
	asamc_wbreq_type req;
	logic            ack;
	logic [31:0]     rdat;
	logic            want_rx;
	logic            mhi;
	logic            mlo;
	logic            sat;
	logic [7:0]      peak;
	logic [7:0]      thr;
	logic            amp1;
	logic            amp2;
	logic            gain;
	logic            pden;
	logic            rxm;
	logic            rdy;
	int              failures;
	int              tests_run;
	// attack constant in cycles, rounded up, for the reset capacitance
	localparam int   ATK_CYC = (int'(PEAK_CAP_RST) * 1000
		+ ATTACK_DIV * CLK_NS - 1) / (ATTACK_DIV * CLK_NS);

	asamc_top #(.POWERUP_CYCLES(20)) dut_u (
		.REF_CLK(clk), .RST(rst), .WB_REQ(req), .WB_ACK(ack),
		.WB_DAT_O(rdat), .MODE_CTRL_HI(mhi), .MODE_CTRL_LO(mlo),
		.GAIN_REDUCE_REQUEST(sat), .PEAK_LEVEL(peak), .SLICE_THRESH(thr),
		.FIRST_RF_AMP_ON(amp1), .SECOND_RF_AMP_ON(amp2),
		.GAIN_SELECT_LOW(gain), .PEAK_DET_EN(pden), .RX_MODE(rxm),
		.RX_READY(rdy)
	);
	asamc_host_model host_u (
		.clk(clk), .want_rx(want_rx), .mode_hi(mhi), .mode_lo(mlo)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b1, we, 4'hf, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		req <= '0;
		chk(ack, 1'b1);
	endtask : wb

	function automatic logic sig(input int k);
		case (k)
			0: return gain;
			1: return rxm;
			2: return amp1;
			default: return rdy;
		endcase
	endfunction : sig

	task automatic waitv(input int k, input logic v, input int lim);
		int n = 0;
		while (sig(k) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(sig(k), v);
	endtask : waitv

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// one first-amp cycle: width, second-amp width, first-amp low time
	task automatic meas(input int e1, input int e2, input int eg);
		int a1 = 0;
		int a2 = 0;
		int g = 0;
		waitv(2, 1'b0, 300);
		waitv(2, 1'b1, 300);
		while (amp1 === 1'b1 && a1 < 300) begin
			a1++;
			@(negedge clk);
		end
		while (amp1 === 1'b0 && g < 300) begin
			if (amp2 === 1'b1) a2++;
			g++;
			@(negedge clk);
		end
		chk(a1, e1);
		chk(a2, e2);
		chk(g, eg);
	endtask : meas

	task automatic engage(input logic [7:0] p, input logic [7:0] t);
		@(posedge clk);
		sat <= 1'b1;
		peak <= p;
		thr <= t;
		waitv(0, 1'b1, 125);
		@(posedge clk);
		sat <= 1'b0;
	endtask : engage

	task automatic t_regs;
		logic [31:0] q;
		wb(0, ADR_GAP, 0, q);
		chk(q, 32'(GAP_RST));
		wb(0, ADR_WIDTH, 0, q);
		chk(q, 32'(WIDTH_RST));
		wb(0, ADR_PERIOD, 0, q);
		chk(q, 32'(PERIOD_RST));
		wb(0, 8'h40, 0, q);
		chk(q, 32'h0);
		wb(0, ADR_STATUS, 0, q);
		chk(q, {16'(ATK_CYC), 16'h0});
		wb(0, ADR_DECAY, 0, q);
		chk(q, 32'(ATK_CYC * DECAY_RATIO));
		chk(pden, 1'b1);
		chk({amp1, amp2}, 2'h0);
	endtask : t_regs

	task automatic t_wake;
		logic [31:0] q;
		wb(1, ADR_SETTLE, 32'h20, q);
		want_rx <= 1'b1;
		waitv(1, 1'b1, 20);
		cyc(28);
		chk(rdy, 1'b0);
		waitv(3, 1'b1, 12);
		wb(0, ADR_STATUS, 0, q);
		chk(32'(q[3:0]), 32'hb);
	endtask : t_wake

	task automatic t_rate;
		logic [31:0] q;
		wb(1, ADR_WIDTH, 32'd20, q);
		wb(1, ADR_GAP, 32'd30, q);
		meas(20, 22, 30);
		wb(1, ADR_WIDTH, 32'd14, q);
		wb(1, ADR_GAP, 32'd3, q);
		meas(14, 16, 16);
		wb(1, ADR_WIDTH, 32'd200, q);
		wb(1, ADR_GAP, 32'd125, q);
		meas(25, 28, 125);
		wb(1, ADR_CTRL, 32'h1, q);
		wb(1, ADR_PERIOD, 32'd10, q);
		meas(5, 5, 5);
		wb(1, ADR_PERIOD, 32'd27, q);
		meas(13, 14, 14);
		wb(1, ADR_PERIOD, 32'd1, q);
		meas(1, 2, 2);
		wb(1, ADR_CTRL, 32'h0, q);
	endtask : t_rate

	task automatic t_gain;
		logic [31:0] q;
		wb(1, ADR_HOLD_CAP, 32'h10, q);
		engage(8'h04, 8'h04);
		cyc(24);
		chk(gain, 1'b1);
		waitv(0, 1'b0, 40);
		engage(8'h05, 8'h04);
		cyc(60);
		chk(gain, 1'b1);
		@(posedge clk);
		peak <= 8'h04;
		waitv(0, 1'b0, 10);
		wb(1, ADR_CTRL, 32'h4, q);
		chk(pden, 1'b0);
		@(posedge clk);
		sat <= 1'b1;
		cyc(50);
		chk(gain, 1'b0);
		@(posedge clk);
		sat <= 1'b0;
		wb(1, ADR_CTRL, 32'h8, q);
		chk(pden, 1'b1);
		engage(8'h04, 8'h04);
		cyc(60);
		chk(gain, 1'b1);
	endtask : t_gain

	task automatic t_sleep;
		@(posedge clk);
		want_rx <= 1'b0;
		waitv(1, 1'b0, SLEEP_MAX_CYC);
		cyc(2);
		chk({amp1, amp2}, 2'h0);
		cyc(100);
		chk({amp1, amp2}, 2'h0);
	endtask : t_sleep

	task summarize;
		$display("checks=%0d mismatches=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	always @(negedge clk) begin
		if (amp1 === 1'b1 && amp2 === 1'b1) chk(1'b1, 1'b0);
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end

	initial begin
		failures = 0;
		tests_run = 0;
		rst = 1'b1;
		req = '0;
		want_rx = 1'b0;
		sat = 1'b0;
		peak = 8'h00;
		thr = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_wake();
		t_rate();
		t_gain();
		t_sleep();
		summarize();
	end
endmodule : amp_sequencer_agc_mode_ctrl_tb

// File: bench/asamc_host_model.sv
`timescale 1ns/1ps
module asamc_host_model (
	input  wire logic clk,
	input  wire logic want_rx,
	output logic      mode_hi,
	output logic      mode_lo
);
	// pins always driven; second pin follows one cycle late
	initial begin
		mode_hi = 1'b0;
		mode_lo = 1'b0;
		forever begin
			@(posedge clk);
			mode_hi <= want_rx;
			mode_lo <= mode_hi;
		end
	end
endmodule : asamc_host_model

// File: rtl/asamc_pkg.sv
package asamc_pkg;
	localparam int          CLK_NS        = 40;
	localparam int          GAP_MIN_NS    = 100;
	localparam int          GAP_MAX_NS    = 5000;
	localparam int          PW1_MIN_NS    = 550;
	localparam int          PW1_MAX_NS    = 1000;
	localparam int          PRC_MIN_NS    = 100;
	localparam int          PRC_MAX_NS    = 1100;
	localparam int          SLEEP_MAX_NS  = 10000;
	localparam int          POWERUP_NS    = 5000000;
	localparam int          PW2_NUM       = 11;
	localparam int          PW2_DEN       = 10;
	localparam int          HOLD_DIV_X10  = 191;
	localparam int          ATTACK_DIV    = 4167;
	localparam int          DECAY_RATIO   = 1000;
	localparam logic [7:0]  GAP_MIN_CYC   =
		8'((GAP_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  GAP_MAX_CYC   = 8'(GAP_MAX_NS / CLK_NS);
	localparam logic [7:0]  PW1_MIN_CYC   =
		8'((PW1_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  PW1_MAX_CYC   = 8'(PW1_MAX_NS / CLK_NS);
	localparam logic [7:0]  PRC_MIN_CYC   =
		8'((PRC_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  PRC_MAX_CYC   = 8'(PRC_MAX_NS / CLK_NS);
	localparam int          SLEEP_MAX_CYC = SLEEP_MAX_NS / CLK_NS;
	localparam int          POWERUP_CYC   = POWERUP_NS / CLK_NS;
	// pF to cycles: us = pF / div, cycles = us * 1000 / CLK_NS
	localparam logic [31:0] HOLD_NUM      = 32'h2710;
	localparam logic [31:0] HOLD_DEN      = 32'(HOLD_DIV_X10 * CLK_NS);
	localparam logic [31:0] ATTACK_NUM    = 32'h3e8;
	localparam logic [31:0] ATTACK_DEN    = 32'(ATTACK_DIV * CLK_NS);
	localparam logic [7:0]  ADR_CTRL      = 8'h00;
	localparam logic [7:0]  ADR_GAP       = 8'h04;
	localparam logic [7:0]  ADR_WIDTH     = 8'h08;
	localparam logic [7:0]  ADR_PERIOD    = 8'h0c;
	localparam logic [7:0]  ADR_HOLD_CAP  = 8'h10;
	localparam logic [7:0]  ADR_PEAK_CAP  = 8'h14;
	localparam logic [7:0]  ADR_SETTLE    = 8'h18;
	localparam logic [7:0]  ADR_STATUS    = 8'h1c;
	localparam logic [7:0]  ADR_DECAY     = 8'h20;
	localparam int          CTRL_HIGH_BIT = 0;
	localparam int          CTRL_PREF_BIT = 1;
	localparam int          CTRL_STRAP_LO = 2;
	localparam logic [1:0]  STRAP_CAP     = 2'h0;
	localparam logic [1:0]  STRAP_DEFEAT  = 2'h1;
	localparam logic [1:0]  STRAP_LATCH   = 2'h2;
	localparam logic [3:0]  CTRL_RST      = 4'h0;
	localparam logic [7:0]  GAP_RST       = 8'h0c;
	localparam logic [7:0]  WIDTH_RST     = 8'h0e;
	localparam logic [7:0]  PERIOD_RST    = 8'h0a;
	localparam logic [15:0] HOLD_CAP_RST  = 16'h0200;
	localparam logic [15:0] PEAK_CAP_RST  = 16'h1000;
	localparam logic [15:0] SETTLE_RST    = 16'h0100;

	typedef enum logic [1:0] {SQ_OFF, SQ_AMP1, SQ_AMP2, SQ_GAP}
		asamc_seq_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} asamc_wbreq_type;
endpackage : asamc_pkg

// File: rtl/asamc_top.sv
`timescale 1ns/1ps
module asamc_top #(
	parameter int POWERUP_CYCLES = asamc_pkg::POWERUP_CYC
) (
	input  wire logic                       REF_CLK,
	input  wire logic                       RST,
	input  wire asamc_pkg::asamc_wbreq_type WB_REQ,
	output logic                            WB_ACK,
	output logic [31:0]                     WB_DAT_O,
	input  wire logic                       MODE_CTRL_HI,
	input  wire logic                       MODE_CTRL_LO,
	input  wire logic                       GAIN_REDUCE_REQUEST,
	input  wire logic [7:0]                 PEAK_LEVEL,
	input  wire logic [7:0]                 SLICE_THRESH,
	output logic                            FIRST_RF_AMP_ON,
	output logic                            SECOND_RF_AMP_ON,
	output logic                            GAIN_SELECT_LOW,
	output logic                            PEAK_DET_EN,
	output logic                            RX_MODE,
	output logic                            RX_READY
);
	import asamc_pkg::*;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	function automatic logic [7:0] clamp8(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction : clamp8

	function automatic logic [31:0] scale_up(input logic [15:0] c,
		input logic [31:0] num, input logic [31:0] den);
		return (32'(c) * num + den - 32'd1) / den;
	endfunction : scale_up

	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = dat[8*i +: 8];
		return r;
	endfunction : lanes

	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [3:0]  ctrl_reg;
	logic [7:0]  gap_reg;
	logic [7:0]  width_reg;
	logic [7:0]  period_reg;
	logic [15:0] hold_cap_reg;
	logic [15:0] peak_cap_reg;
	logic [15:0] settle_reg;
	logic        wb_hit;
	logic        wb_wr;
	logic [31:0] wdat;

	assign wb_hit = WB_REQ.cyc & WB_REQ.stb & ~ack_reg;
	assign wb_wr  = wb_hit & WB_REQ.we;

	// bus answer one edge after the request is seen
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg <= wb_hit;
			if (wb_hit)
				rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_reg     <= CTRL_RST;
			gap_reg      <= GAP_RST;
			width_reg    <= WIDTH_RST;
			period_reg   <= PERIOD_RST;
			hold_cap_reg <= HOLD_CAP_RST;
			peak_cap_reg <= PEAK_CAP_RST;
			settle_reg   <= SETTLE_RST;
		end else if (wb_wr) begin
			case (WB_REQ.adr)
			ADR_CTRL: begin
				ctrl_reg <= wdat[3:0];
			end
			ADR_GAP: begin
				gap_reg <= clamp8(wdat[7:0], GAP_MIN_CYC,
					GAP_MAX_CYC);
			end
			ADR_WIDTH: begin
				width_reg <= clamp8(wdat[7:0], PW1_MIN_CYC,
					PW1_MAX_CYC);
			end
			ADR_PERIOD: begin
				period_reg <= clamp8(wdat[7:0], PRC_MIN_CYC,
					PRC_MAX_CYC);
			end
			ADR_HOLD_CAP: begin
				hold_cap_reg <= wdat[15:0];
			end
			ADR_PEAK_CAP: begin
				peak_cap_reg <= wdat[15:0];
			end
			ADR_SETTLE: begin
				settle_reg <= wdat[15:0];
			end
			default: begin
			end
			endcase
		end
	end

	// old contents under the byte lanes that are not written
	always_comb begin
		case (WB_REQ.adr)
		ADR_CTRL:     wdat = lanes({28'h0, ctrl_reg}, WB_REQ.dat, WB_REQ.sel);
		ADR_GAP:      wdat = lanes({24'h0, gap_reg}, WB_REQ.dat, WB_REQ.sel);
		ADR_WIDTH:    wdat = lanes({24'h0, width_reg}, WB_REQ.dat,
			WB_REQ.sel);
		ADR_PERIOD:   wdat = lanes({24'h0, period_reg}, WB_REQ.dat,
			WB_REQ.sel);
		ADR_HOLD_CAP: wdat = lanes({16'h0, hold_cap_reg}, WB_REQ.dat,
			WB_REQ.sel);
		ADR_PEAK_CAP: wdat = lanes({16'h0, peak_cap_reg}, WB_REQ.dat,
			WB_REQ.sel);
		ADR_SETTLE:   wdat = lanes({16'h0, settle_reg}, WB_REQ.dat,
			WB_REQ.sel);
		default:      wdat = 32'h0;
		endcase
	end

	logic        high_rate;
	logic [1:0]  strap;
	logic        agc_en;
	logic [31:0] hold_cyc;
	logic [31:0] attack_cyc;
	logic [31:0] decay_cyc;

	assign high_rate  = ctrl_reg[CTRL_HIGH_BIT];
	assign strap      = ctrl_reg[CTRL_STRAP_LO +: 2];
	assign agc_en     = strap != STRAP_DEFEAT;
	assign hold_cyc   = scale_up(hold_cap_reg, HOLD_NUM, HOLD_DEN);
	assign attack_cyc = scale_up(peak_cap_reg, ATTACK_NUM,
		ATTACK_DEN);
	assign decay_cyc  = 32'(attack_cyc * DECAY_RATIO);

	// three-stage input synchronisers for the pins
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] sync3_reg;
	logic [2:0] filt_reg;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
			filt_reg  <= 3'h0;
		end else begin
			sync1_reg <= {GAIN_REDUCE_REQUEST, MODE_CTRL_LO, MODE_CTRL_HI};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int i = 0; i < 3; i++)
				if (sync2_reg[i] == sync3_reg[i])
					filt_reg[i] <= sync3_reg[i];
		end
	end

	logic rx_mode_reg;
	logic run;

	// mixed pin levels keep the present mode
	always_ff @(posedge REF_CLK) begin
		if (RST)
			rx_mode_reg <= 1'b0;
		else if (filt_reg[0] && filt_reg[1])
			rx_mode_reg <= 1'b1;
		else if (!filt_reg[0] && !filt_reg[1])
			rx_mode_reg <= 1'b0;
	end

	logic [31:0] pwr_cnt_reg;
	logic        powered_reg;
	logic [15:0] settle_cnt_reg;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pwr_cnt_reg <= 32'h0;
			powered_reg <= 1'b0;
		end else if (!powered_reg) begin
			pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
			if (pwr_cnt_reg >= 32'(POWERUP_CYCLES - 1))
				powered_reg <= 1'b1;
		end
	end

	assign run = rx_mode_reg & powered_reg;

	// coupling capacitor settle after wake or power-up
	always_ff @(posedge REF_CLK) begin
		if (RST || !run)
			settle_cnt_reg <= settle_reg;
		else if (settle_cnt_reg != 16'h0)
			settle_cnt_reg <= settle_cnt_reg - 16'h1;
	end

	logic        gain_low_reg;
	logic [31:0] hold_cnt_reg;
	logic        restore;

	// peak * 0.8 < threshold, kept in integers
	assign restore = (11'(PEAK_LEVEL) << 2) <
		(11'(SLICE_THRESH) + (11'(SLICE_THRESH) << 2));

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			gain_low_reg <= 1'b0;
			hold_cnt_reg <= 32'h0;
		end else if (!agc_en) begin
			gain_low_reg <= 1'b0;
			hold_cnt_reg <= 32'h0;
		end else if (filt_reg[2]) begin
			gain_low_reg <= 1'b1;
			hold_cnt_reg <= hold_cyc;
		end else begin
			if (hold_cnt_reg != 32'h0)
				hold_cnt_reg <= hold_cnt_reg - 32'h1;
			if (restore && hold_cnt_reg == 32'h0 && strap != STRAP_LATCH)
				gain_low_reg <= 1'b0;
		end
	end

	asamc_seq_type state_reg;
	logic [7:0]    cnt_reg;
	logic [7:0]    w1;
	logic [7:0]    w2;
	logic [7:0]    span;
	logic [7:0]    pw2;

	assign pw2 = 8'((16'(width_reg) * 16'(PW2_NUM) + 16'(PW2_DEN - 1))
		/ 16'(PW2_DEN));

	// span is the first amp off time, second amp pulse sits inside it
	always_comb begin
		if (high_rate) begin
			w1   = period_reg >> 1;
			w2   = period_reg - w1;
			span = w2;
		end else begin
			w1   = width_reg;
			w2   = pw2;
			span = (gap_reg > pw2) ? gap_reg : pw2;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST || !run) begin
			state_reg <= SQ_OFF;
			cnt_reg   <= 8'h0;
		end else begin
			case (state_reg)
			SQ_OFF: begin
				state_reg <= SQ_AMP1;
				cnt_reg   <= 8'h0;
			end
			SQ_AMP1: begin
				if (cnt_reg >= w1 - 8'h1) begin
					state_reg <= SQ_AMP2;
					cnt_reg   <= 8'h0;
				end else
					cnt_reg <= cnt_reg + 8'h1;
			end
			SQ_AMP2, SQ_GAP: begin
				if (cnt_reg >= span - 8'h1) begin
					state_reg <= SQ_AMP1;
					cnt_reg   <= 8'h0;
				end else begin
					cnt_reg <= cnt_reg + 8'h1;
					if (cnt_reg >= w2 - 8'h1)
						state_reg <= SQ_GAP;
				end
			end
			default: begin
				state_reg <= SQ_OFF;
			end
			endcase
		end
	end

	always_comb begin
		case (WB_REQ.adr)
		ADR_CTRL:     rdata_next = {28'h0, ctrl_reg};
		ADR_GAP:      rdata_next = {24'h0, gap_reg};
		ADR_WIDTH:    rdata_next = {24'h0, width_reg};
		ADR_PERIOD:   rdata_next = {24'h0, period_reg};
		ADR_HOLD_CAP: rdata_next = {16'h0, hold_cap_reg};
		ADR_PEAK_CAP: rdata_next = {16'h0, peak_cap_reg};
		ADR_SETTLE:   rdata_next = {16'h0, settle_reg};
		ADR_STATUS:   rdata_next = {attack_cyc[15:0], 12'h0, powered_reg,
			gain_low_reg, RX_READY, rx_mode_reg};
		ADR_DECAY:    rdata_next = decay_cyc;
		default:      rdata_next = 32'h0;
		endcase
	end

	assign WB_ACK           = ack_reg;
	assign WB_DAT_O         = rdata_reg;
	assign FIRST_RF_AMP_ON  = state_reg == SQ_AMP1;
	assign SECOND_RF_AMP_ON = state_reg == SQ_AMP2;
	assign GAIN_SELECT_LOW  = gain_low_reg;
	assign PEAK_DET_EN      = agc_en | ctrl_reg[CTRL_PREF_BIT];
	assign RX_MODE          = rx_mode_reg;
	assign RX_READY         = run & (settle_cnt_reg == 16'h0);

	sequence s_pins_low;
		(!MODE_CTRL_HI && !MODE_CTRL_LO) [*6];
	endsequence

	sequence s_amps_off;
		(!FIRST_RF_AMP_ON && !SECOND_RF_AMP_ON) [*2];
	endsequence

	a_amp_exclusive: assert property (
		!(FIRST_RF_AMP_ON && SECOND_RF_AMP_ON))
		else $error("both amplifier enables on");

	a_sleep_quiet: assert property (
		!run |=> !FIRST_RF_AMP_ON && !SECOND_RF_AMP_ON)
		else $error("amplifier on during power-down");

	a_sleep_reach: assert property (
		s_pins_low |=> !RX_MODE ##0 s_amps_off)
		else $error("sleep not reached after mode pins low");

	a_mode_rx: assert property (
		filt_reg[0] && filt_reg[1] |=> RX_MODE)
		else $error("receive mode not entered");

	a_gain_set: assert property (
		agc_en && filt_reg[2] |=> GAIN_SELECT_LOW)
		else $error("low gain not selected on saturation");

	a_gain_defeat: assert property (
		!agc_en |=> !GAIN_SELECT_LOW)
		else $error("gain control active while defeated");

	a_gain_latch: assert property (
		GAIN_SELECT_LOW && strap == STRAP_LATCH && $stable(ctrl_reg)
		|=> GAIN_SELECT_LOW)
		else $error("latched low gain released");

	a_gain_hold: assert property (
		$fell(GAIN_SELECT_LOW) && $past(agc_en) |-> ~|$past(hold_cnt_reg))
		else $error("gain restored before hold-in ended");

	a_gap_min: assert property (
		$fell(FIRST_RF_AMP_ON) && run && !high_rate |-> !FIRST_RF_AMP_ON [*3])
		else $error("first amplifier gap too short");

	a_amp2_follows: assert property (
		$fell(FIRST_RF_AMP_ON) && run |-> SECOND_RF_AMP_ON)
		else $error("second amplifier did not follow first");

	a_peak_on: assert property (
		agc_en |-> PEAK_DET_EN)
		else $error("peak detector off with gain control on");
endmodule : asamc_top
